// ### gsc_top.sv
// gated switch control: oscillator, latches, blanking, supply modes, apb
// assumes comparator flags already synchronous to pclk
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module gsc_top
   import gsc_pkg::*;
#(
   parameter int FREQ_OPT = 1,
   parameter int CNT_W = 12
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ctrl_flag,
   input wire logic ilim_flag,
   input wire logic supply_at_on,
   input wire logic supply_at_off,
   input wire logic supply_at_reset,
   input wire logic supply_lockout,
   output logic switch_drive,
   output logic startup_source_on,
   output logic low_power,
   output logic irq
);

   // -----------------------------------------------------------------
   // derived oscillator figures
   // -----------------------------------------------------------------
   localparam int FREQ_HZ = (FREQ_OPT == 0) ? FREQ_44K_HZ :
                            (FREQ_OPT == 1) ? FREQ_100K_HZ : FREQ_136K_HZ;
   localparam int BASE_CYC = CLK_HZ / FREQ_HZ;
   localparam int LOW_CYC = BASE_CYC - DITHER_STEPS / 2;
   localparam logic [CNT_W-1:0] LOW_PERIOD = CNT_W'(LOW_CYC);
   localparam logic [CNT_W-1:0] BLANK_LOAD = CNT_W'(LEB_CYC);

   initial
   begin
      if (FREQ_OPT < 0 || FREQ_OPT > 2)
         $error("FREQ_OPT must be 0, 1 or 2");
      if ((BASE_CYC + DITHER_STEPS) >= (1 << CNT_W))
         $error("CNT_W too narrow for oscillator period");
   end

   // -----------------------------------------------------------------
   // control registers
   // -----------------------------------------------------------------
   logic [1:0] ctrl;
   logic [IRQ_W-1:0] irq_status;
   logic [IRQ_W-1:0] irq_mask;
   logic [IRQ_W-1:0] irq_event;
   gsc_mode_type mode;
   gsc_mode_type next_mode;

   logic bus_access;
   logic bus_commit;
   logic addr_ok;
   assign bus_access = psel && penable && !pready;
   assign bus_commit = psel && penable && pready;
   assign addr_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_STATE) ||
                    (paddr == ADDR_IRQ_STATUS) || (paddr == ADDR_IRQ_MASK) ||
                    (paddr == ADDR_PERIOD);

   // -----------------------------------------------------------------
   // oscillator with supply driven sweep
   // -----------------------------------------------------------------
   logic [CNT_W-1:0] osc_cnt;
   logic [CNT_W-1:0] period;
   logic [CNT_W-1:0] on_limit;
   logic [CNT_W-1:0] dither;
   logic [CNT_W-1:0] next_period;
   logic osc;
   logic osc_wrap;

   assign osc_wrap = (osc_cnt == period - CNT_W'(1));
   assign next_period = LOW_PERIOD + (ctrl[CTRL_DITHER_BIT] ? dither : '0);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         osc_cnt <= '0;
      else if (osc_wrap)
         osc_cnt <= '0;
      else
         osc_cnt <= osc_cnt + CNT_W'(1);
   end

   // supply rising while charged, falling otherwise: sweep follows it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         dither <= '0;
      else if (osc_wrap && startup_source_on && dither < CNT_W'(DITHER_STEPS))
         dither <= dither + CNT_W'(1);
      else if (osc_wrap && !startup_source_on && dither != '0)
         dither <= dither - CNT_W'(1);
   end

   // period and on-time taken at each period boundary
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         period <= CNT_W'(BASE_CYC);
         on_limit <= CNT_W'(BASE_CYC * DUTY_PCT / PCT_FULL);
      end
      else if (osc_wrap)
      begin
         period <= next_period;
         // product formed at 32 bits, the counter width would wrap it
         on_limit <= CNT_W'((32'(next_period) * DUTY_PCT) / PCT_FULL);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         osc <= 1'b0;
      else
         osc <= !osc_wrap && (osc_cnt + CNT_W'(1) < on_limit);
   end

   // -----------------------------------------------------------------
   // turn-on and turn-off latches, blanking
   // -----------------------------------------------------------------
   logic on_latch;
   logic on_latch_d;
   logic off_latch;
   logic [CNT_W-1:0] blank_cnt;
   logic ilim_seen;
   logic switching_ok;

   assign ilim_seen = ilim_flag && (blank_cnt == '0);
   assign switching_ok = (mode == gsc_run) && ctrl[CTRL_RUN_BIT];

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         on_latch <= 1'b0;
      else if (!osc)
         on_latch <= 1'b0;
      else if (!ctrl_flag)
         on_latch <= 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         on_latch_d <= 1'b0;
      else
         on_latch_d <= on_latch;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         off_latch <= 1'b0;
      else if (!osc || ctrl_flag || ilim_seen)
         off_latch <= 1'b0;
      else if (on_latch && !on_latch_d)
         off_latch <= 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         blank_cnt <= '0;
      else if (on_latch && !on_latch_d)
         blank_cnt <= BLANK_LOAD;
      else if (blank_cnt != '0)
         blank_cnt <= blank_cnt - CNT_W'(1);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         switch_drive <= 1'b0;
      else
         switch_drive <= off_latch && osc && !ilim_seen && !supply_lockout &&
                         switching_ok;
   end

   // -----------------------------------------------------------------
   // supply modes and fault timer
   // -----------------------------------------------------------------
   logic timing;
   logic ctrl_seen;
   logic timer_end;

   assign timer_end = (mode == gsc_run) && timing && supply_at_off;

   always_comb
   begin
      next_mode = mode;
      unique case (mode)
         gsc_lockout:
            if (supply_at_on && !supply_lockout)
               next_mode = gsc_run;
         gsc_run:
            if (timer_end && !ctrl_seen && !ctrl_flag)
               next_mode = gsc_fault_drain;
            else if (supply_lockout)
               next_mode = gsc_lockout;
         gsc_fault_drain:
            if (supply_at_reset)
               next_mode = gsc_fault_charge;
         gsc_fault_charge:
            if (supply_at_on)
               next_mode = gsc_run;
         default:
            next_mode = gsc_lockout;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mode <= gsc_lockout;
      else
         mode <= next_mode;
   end

   // timer period opens at the upper threshold, closes at the lower one
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         timing <= 1'b0;
      else if (next_mode != gsc_run)
         timing <= 1'b0;
      else if (supply_at_on)
         timing <= 1'b1;
      else if (timer_end)
         timing <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl_seen <= 1'b0;
      else if (supply_at_on || next_mode != gsc_run)
         ctrl_seen <= 1'b0;
      else if (ctrl_flag)
         ctrl_seen <= 1'b1;
   end

   // hysteretic self supply and recharge control
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         startup_source_on <= 1'b1;
      else
         unique case (next_mode)
            gsc_lockout:
               startup_source_on <= 1'b1;
            gsc_fault_drain:
               startup_source_on <= 1'b0;
            gsc_fault_charge:
               startup_source_on <= 1'b1;
            gsc_run:
               if (supply_at_on)
                  startup_source_on <= 1'b0;
               else if (supply_at_off)
                  startup_source_on <= 1'b1;
            default:
               startup_source_on <= 1'b1;
         endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         low_power <= 1'b0;
      else
         low_power <= (next_mode == gsc_fault_drain);
   end

   // -----------------------------------------------------------------
   // interrupts
   // -----------------------------------------------------------------
   always_comb
   begin
      irq_event = '0;
      irq_event[IRQ_FAULT_BIT] = (mode == gsc_run) && (next_mode == gsc_fault_drain);
      irq_event[IRQ_LOCKOUT_BIT] = (mode == gsc_run) && (next_mode == gsc_lockout);
      irq_event[IRQ_ILIM_BIT] = off_latch && ilim_seen;
      irq_event[IRQ_RECOVER_BIT] = (mode == gsc_fault_charge) && (next_mode == gsc_run);
   end

   // set wins over a simultaneous write-one clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_status <= '0;
      else if (bus_commit && pwrite && paddr == ADDR_IRQ_STATUS)
         irq_status <= (irq_status & ~pwdata[IRQ_W-1:0]) | irq_event;
      else
         irq_status <= irq_status | irq_event;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq <= 1'b0;
      else
         irq <= |(irq_status & irq_mask);
   end

   // -----------------------------------------------------------------
   // apb slave: one wait state, pslverr on unmapped addresses
   // -----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pready <= 1'b0;
      else
         pready <= bus_access;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pslverr <= 1'b0;
      else
         pslverr <= bus_access && !addr_ok;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= '0;
      else if (bus_access && !pwrite)
         unique case (paddr)
            ADDR_CTRL: prdata <= {30'h0, ctrl};
            ADDR_STATE: prdata <= {23'h0, ctrl_seen, timing, off_latch, on_latch, osc,
                                   low_power, 3'(mode)};
            ADDR_IRQ_STATUS: prdata <= {28'h0, irq_status};
            ADDR_IRQ_MASK: prdata <= {28'h0, irq_mask};
            ADDR_PERIOD: prdata <= 32'(period);
            default: prdata <= '0;
         endcase
      else if (bus_access)
         prdata <= '0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl <= CTRL_RESET;
      else if (bus_commit && pwrite && paddr == ADDR_CTRL)
         ctrl <= pwdata[1:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_mask <= IRQ_MASK_RESET;
      else if (bus_commit && pwrite && paddr == ADDR_IRQ_MASK)
         irq_mask <= pwdata[IRQ_W-1:0];
   end

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   logic [CNT_W-1:0] drive_run;
   logic [1:0] pulses;
   logic off_latch_d;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         off_latch_d <= 1'b0;
      else
         off_latch_d <= off_latch;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         drive_run <= '0;
      else if (switch_drive)
         drive_run <= drive_run + CNT_W'(1);
      else
         drive_run <= '0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pulses <= '0;
      else if (!osc)
         pulses <= '0;
      else if (off_latch && !off_latch_d && pulses != 2'h3)
         pulses <= pulses + 2'h1;
   end

   a_duty_limit: assert property (@(posedge pclk) disable iff (!presetn)
      drive_run <= on_limit)
      else $error("switch on longer than duty limit");

   a_onlatch_clear: assert property (@(posedge pclk) disable iff (!presetn)
      !osc |=> !on_latch)
      else $error("turn-on latch not cleared in off time");

   a_ctrl_blocks: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_flag |=> !off_latch ##1 !switch_drive)
      else $error("control flag did not end conduction");

   a_ilim_trip: assert property (@(posedge pclk) disable iff (!presetn)
      (ilim_flag && blank_cnt == '0) |=> !off_latch)
      else $error("current limit did not reset turn-off latch");

   a_single_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      pulses <= 2'h1)
      else $error("more than one pulse in a period");

   a_leb_window: assert property (@(posedge pclk) disable iff (!presetn)
      (on_latch && !on_latch_d) |=> (blank_cnt == BLANK_LOAD))
      else $error("blanking not started at turn-on");

   a_leb_mask: assert property (@(posedge pclk) disable iff (!presetn)
      (off_latch && blank_cnt != '0 && osc && !ctrl_flag) |=> off_latch)
      else $error("current limit not masked while blanking");

   a_lockout_src: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == gsc_run && supply_lockout && !timer_end) |=> ##1
      (startup_source_on && !switch_drive))
      else $error("lockout did not restart startup phase");

   a_fault_entry: assert property (@(posedge pclk) disable iff (!presetn)
      (timer_end && !ctrl_seen && !ctrl_flag) |=> (mode == gsc_fault_drain) ##1
      (low_power && !startup_source_on))
      else $error("missing fault after silent timer period");

   a_fault_restart: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == gsc_fault_charge && supply_at_on) |=> (mode == gsc_run) && timing)
      else $error("burst restart did not rerun timer");

   a_drive_gate: assert property (@(posedge pclk) disable iff (!presetn)
      switch_drive |-> $past(off_latch && osc && mode == gsc_run))
      else $error("drive without latch, oscillator or run mode");

endmodule : gsc_top

`default_nettype wire

// ### gsc_pkg.sv
// gated switch control: shared constants, register map and types
// assumes a single 25 MHz clock and active-low asynchronous reset
package gsc_pkg;

   // -----------------------------------------------------------------
   // clock and timing
   // -----------------------------------------------------------------
   localparam int CLK_HZ = 25_000_000;
   localparam int CLK_NS = 40;
   localparam int FREQ_44K_HZ = 44_000;
   localparam int FREQ_100K_HZ = 100_000;
   localparam int FREQ_136K_HZ = 136_000;
   localparam int DUTY_PCT = 77;
   localparam int PCT_FULL = 100;
   localparam int LEB_NS = 200;
   localparam int LEB_CYC = (LEB_NS + CLK_NS - 1) / CLK_NS;
   localparam int DITHER_STEPS = 16;

   // -----------------------------------------------------------------
   // register map (byte addresses)
   // -----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATE = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
   localparam logic [7:0] ADDR_PERIOD = 8'h10;

   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_DITHER_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h3;

   localparam int IRQ_W = 4;
   localparam int IRQ_FAULT_BIT = 0;
   localparam int IRQ_LOCKOUT_BIT = 1;
   localparam int IRQ_ILIM_BIT = 2;
   localparam int IRQ_RECOVER_BIT = 3;
   localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

   // -----------------------------------------------------------------
   // supply mode states
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      gsc_lockout,
      gsc_run,
      gsc_fault_drain,
      gsc_fault_charge
   } gsc_mode_type;

endpackage : gsc_pkg

// ### gsc_far_model.sv
// gsc far side: feedback loop, primary current, supply capacitor
// assumes the control block's pclk; levels change after rising edges
`timescale 1ns/1ps
`default_nettype none

module gsc_far_model
#(
   parameter int FB_DLY = 1
)
(
   input wire logic pclk,
   input wire logic switch_drive,
   input wire logic startup_source_on,
   input wire logic low_power,
   input wire logic fb_en,
   input wire logic force_lo,
   input wire logic spike_en,
   input wire logic [7:0] ilim_lvl,
   output logic ctrl_flag,
   output logic ilim_flag,
   output logic supply_at_on,
   output logic supply_at_off,
   output logic supply_at_reset,
   output logic supply_lockout
);
   // supply and output in millivolts, primary current in cycles
   int sup = 0;
   int vout = 0;
   int ipk = 0;
   logic [7:0] fb_pipe = 8'h00;

   function automatic int lim(input int v, input int lo, input int hi);
      return (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction : lim

   // ---------------------------------------------
   // analog state
   // ---------------------------------------------
   always @(posedge pclk)
   begin
      sup <= lim(sup + (startup_source_on ? 4 : 0) - (low_power ? 1 : 2), 0, 9000);
      vout <= lim(vout + (switch_drive ? 3 : 0) - 1, 0, 600);
      ipk <= switch_drive ? ipk + 1 : 0;
      fb_pipe <= {fb_pipe[6:0], fb_en && vout > 300};
   end

   // ---------------------------------------------
   // comparator flags
   // ---------------------------------------------
   assign ctrl_flag = fb_pipe[FB_DLY - 1];
   // turn-on spike lasts two cycles, inside the blanking time
   assign ilim_flag = (spike_en && switch_drive && ipk < 2) || ipk >= int'(ilim_lvl);
   assign supply_at_on = sup >= 8600;
   assign supply_at_off = sup <= 7600;
   assign supply_at_reset = sup <= 4600;
   assign supply_lockout = force_lo || sup < 4200;

endmodule : gsc_far_model
`default_nettype wire

// ### gsc_tb.sv
// gsc testbench: register rows, regulation, fault burst, lockout
// assumes gsc_top at FREQ_OPT 2 facing gsc_far_model
`timescale 1ns/1ps
`default_nettype none

module tb
   import gsc_pkg::*;
;
   localparam int BASE = 183;
   localparam int MAX_ON = (BASE + 8) * DUTY_PCT / PCT_FULL;
   localparam int MIN_OFF = (BASE - 8) - (BASE - 8) * DUTY_PCT / PCT_FULL - 2;

   typedef struct {
      logic wr;
      logic [7:0] a;
      logic [31:0] d;
      logic [31:0] m;
      logic [31:0] e;
      logic se;
   } gsc_row_type;

   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ctrl_flag, ilim_flag;
   logic supply_at_on, supply_at_off, supply_at_reset, supply_lockout, switch_drive;
   logic startup_source_on, low_power, irq, fb_en, force_lo, spike_en, se;
   logic [7:0] paddr, ilim_lvl;
   logic [31:0] pwdata, prdata, q;
   int err_count = 0;
   int total_checks = 0;
   int hi_len, lo_len, crun, lrun, orun, frun, prun;
   int lgap = 0;

   gsc_row_type rows [7] = '{
      '{1'b0, ADDR_CTRL, 32'h0, 32'h3, 32'h3, 1'b0},
      '{1'b0, ADDR_IRQ_MASK, 32'h0, 32'hF, 32'h0, 1'b0},
      '{1'b1, ADDR_IRQ_MASK, 32'hF, 32'h0, 32'h0, 1'b0},
      '{1'b0, ADDR_IRQ_MASK, 32'h0, 32'hF, 32'hF, 1'b0},
      '{1'b0, 8'h20, 32'h0, 32'hFFFFFFFF, 32'h0, 1'b1},
      '{1'b1, ADDR_STATE, 32'hFF, 32'h0, 32'h0, 1'b0},
      '{1'b0, ADDR_STATE, 32'h0, 32'h7, 32'h0, 1'b0}
   };

   gsc_top #(.FREQ_OPT(2), .CNT_W(12)) u_gsc_top (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .ctrl_flag, .ilim_flag, .supply_at_on, .supply_at_off,
      .supply_at_reset, .supply_lockout, .switch_drive, .startup_source_on,
      .low_power, .irq
   );

   gsc_far_model #(.FB_DLY(1)) u_gsc_far_model (
      .pclk, .switch_drive, .startup_source_on, .low_power, .fb_en, .force_lo,
      .spike_en, .ilim_lvl, .ctrl_flag, .ilim_flag, .supply_at_on, .supply_at_off,
      .supply_at_reset, .supply_lockout
   );

   // ---------------------------------------------
   // shared tasks
   // ---------------------------------------------
   task automatic conclude();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : conclude

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      total_checks++;
      if (s !== e)
      begin
         $display("ERROR %s expected %0h seen %0h", nm, e, s);
         err_count++;
      end
   endtask : chk

   task automatic wait_sig(input string nm, ref logic s, input logic v, input int n);
      while (s !== v && n > 0)
      begin
         @(posedge pclk);
         n--;
      end
      chk(nm, 32'(v), 32'(s));
      if (s !== v)
         conclude();
   endtask : wait_sig

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      q = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk("pready", 1, 32'(pready));
      if (pready !== 1'b1)
         conclude();
   endtask : apb

   // ---------------------------------------------
   // clock and drive monitor
   // ---------------------------------------------
   initial
   begin
      pclk = 1'b0;
      forever
         #20 pclk = ~pclk;
   end

   always @(posedge pclk)
   begin
      if (presetn !== 1'b1)
      begin
         hi_len = 0;
         lo_len = 1000;
      end
      crun = (ctrl_flag === 1'b1) ? crun + 1 : 0;
      lrun = (supply_lockout === 1'b1) ? lrun + 1 : 0;
      lgap = (supply_lockout === 1'b1) ? 0 : lgap + 1;
      orun = (supply_at_on === 1'b1) ? orun + 1 : 0;
      frun = (supply_at_off === 1'b1) ? frun + 1 : 0;
      prun = (low_power === 1'b1) ? prun + 1 : 0;
      if (presetn === 1'b1)
      begin
         if (crun >= 3 || lrun >= 3 || prun >= 2)
            chk("drive_blocked", 0, 32'(switch_drive));
         if (orun >= 3 && lgap >= 2 && prun == 0)
            chk("src_at_on", 0, 32'(startup_source_on));
         if (frun >= 3 && prun == 0)
            chk("src_at_off", 1, 32'(startup_source_on));
         if (prun >= 2)
            chk("src_fault", 0, 32'(startup_source_on));
         if (switch_drive === 1'b1)
         begin
            if (hi_len == 0)
               chk("off_gap", 1, 32'(lo_len >= MIN_OFF));
            hi_len++;
            lo_len = 0;
         end
         else
         begin
            if (hi_len > 0)
            begin
               chk("on_max", 1, 32'(hi_len <= MAX_ON));
               chk("on_ilim", 1, 32'(hi_len <= int'(ilim_lvl) + 3));
               // a pulse cut by fault entry is not a blanking case
               if (spike_en && prun == 0)
                  chk("on_blank", 1, 32'(hi_len > LEB_CYC));
            end
            hi_len = 0;
            lo_len++;
         end
      end
   end

   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      fb_en = 1'b1;
      force_lo = 1'b0;
      spike_en = 1'b0;
      ilim_lvl = 8'hFF;
      repeat (4) @(posedge pclk);
      chk("rst_src", 1, 32'(startup_source_on));
      chk("rst_drive", 0, 32'(switch_drive));
      chk("rst_irq", 0, 32'(irq));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[i])
      begin
         apb(rows[i].wr, rows[i].a, rows[i].d);
         if (!rows[i].wr)
            chk("rdata", rows[i].e, q & rows[i].m);
         chk("slverr", 32'(rows[i].se), 32'(se));
      end
      apb(1'b0, ADDR_PERIOD, 32'h0);
      chk("period", 1, 32'(q >= BASE - 8 && q <= BASE + 8));
      wait_sig("at_on", supply_at_on, 1'b1, 6000);
      wait_sig("src_off", startup_source_on, 1'b0, 10);
      wait_sig("drive_on", switch_drive, 1'b1, 600);
      repeat (3000) @(posedge pclk);
      chk("no_fault", 0, 32'(low_power));
      // open loop with current limit and turn-on spike
      wait_sig("drive_low", switch_drive, 1'b0, 300);
      fb_en <= 1'b0;
      spike_en <= 1'b1;
      ilim_lvl <= 8'h28;
      wait_sig("fault", low_power, 1'b1, 5000);
      apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
      chk("irq_stat", 32'h5, q & 32'h5);
      chk("irq_up", 1, 32'(irq));
      apb(1'b1, ADDR_IRQ_MASK, 32'h0);
      repeat (2) @(posedge pclk);
      chk("irq_masked", 0, 32'(irq));
      apb(1'b1, ADDR_IRQ_MASK, 32'hF);
      apb(1'b1, ADDR_IRQ_STATUS, 32'hF);
      apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
      chk("irq_clr", 0, q & 32'h5);
      chk("irq_down", 0, 32'(irq));
      fb_en <= 1'b1;
      spike_en <= 1'b0;
      ilim_lvl <= 8'hFF;
      wait_sig("recharge", low_power, 1'b0, 6000);
      @(posedge pclk);
      chk("src_chg", 1, 32'(startup_source_on));
      wait_sig("resume", switch_drive, 1'b1, 3000);
      apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
      chk("irq_burst", 32'h8, q & 32'h8);
      repeat (3000) @(posedge pclk);
      chk("recovered", 0, 32'(low_power));
      // lockout in mid-run
      force_lo <= 1'b1;
      wait_sig("lk_src", startup_source_on, 1'b1, 5);
      apb(1'b0, ADDR_STATE, 32'h0);
      chk("lk_mode", 0, q & 32'h7);
      apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
      chk("lk_irq", 32'h2, q & 32'h2);
      force_lo <= 1'b0;
      wait_sig("lk_on", supply_at_on, 1'b1, 2000);
      wait_sig("lk_off", startup_source_on, 1'b0, 10);
      wait_sig("lk_run", switch_drive, 1'b1, 600);
      conclude();
   end

endmodule : tb
`default_nettype wire
